// ---- include/lsc_pkg.sv ----
package lsc_pkg;

  // register map
  localparam logic [7:0] ADDR_IDENTITY = 8'h03;
  localparam logic [7:0] ADDR_FORCE    = 8'h04;
  localparam logic [7:0] ADDR_ENABLE   = 8'h16;
  localparam logic [7:0] ADDR_CFG98    = 8'h98;
  localparam logic [7:0] ADDR_CFG9E    = 8'h9e;
  localparam logic [3:0] ADDR_CFG_HI   = 4'ha;

  // widths and counts
  localparam int         NUM_OUTPUTS = 6;
  localparam int         CFG_BYTES   = 18;
  localparam logic [3:0] BYTE_BITS   = 4'h8;

  // reset values
  localparam logic [5:0] FORCE_RST  = 6'h00;
  localparam logic [5:0] ENABLE_RST = 6'h3f;

  // config byte positions and factory field positions
  localparam logic [4:0] CFG_IDX_98  = 5'h00;
  localparam logic [4:0] CFG_IDX_9E  = 5'h01;
  localparam logic [4:0] CFG_IDX_A0  = 5'h02;
  localparam int         ILIM_BIT    = 7;
  localparam int         VRANGE_BIT  = 5;

  // preload variants
  localparam int VARIANT_A            = 0;
  localparam int VARIANT_B            = 1;
  localparam int VARIANT_UNCONFIGURED = 2;

  typedef logic [0:CFG_BYTES-1][7:0] lsc_cfg_t;

  // factory tables, byte 0 is 98h, byte 1 is 9eh, then a0h..afh
  localparam lsc_cfg_t CFG_TBL_A = '{8'h00, 8'h22, 8'hff, 8'hcf, 8'h2f, 8'h5e, 8'h72, 8'h14,
                                     8'h80, 8'hff, 8'h00, 8'ha0, 8'h0f, 8'h00, 8'h00, 8'h00,
                                     8'h0f, 8'h02};
  localparam lsc_cfg_t CFG_TBL_B = '{8'h00, 8'h22, 8'hff, 8'h4f, 8'h20, 8'h03, 8'h12, 8'h0c,
                                     8'h80, 8'hff, 8'h00, 8'h80, 8'h0f, 8'h00, 8'h00, 8'h00,
                                     8'h0f, 8'h02};

  // bus state machine
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ACK_ADDR = 7'h04,
    ST_WBYTE    = 7'h08,
    ST_ACK_W    = 7'h10,
    ST_RBYTE    = 7'h20,
    ST_ACK_R    = 7'h40
  } lsc_state_e;

  // preload image for an ordered variant
  function automatic lsc_cfg_t lsc_preload(input int variant, input logic ilim,
                                           input logic vrange);
    lsc_cfg_t c;
    case (variant)
      VARIANT_A: c = CFG_TBL_A;
      VARIANT_B: c = CFG_TBL_B;
      default: begin
        c = '0;
        c[CFG_IDX_98][ILIM_BIT]   = ilim;
        c[CFG_IDX_9E][VRANGE_BIT] = vrange;
      end
    endcase
    return c;
  endfunction

endpackage

// ---- rtl/lsc_line_frontend.sv ----
`timescale 1ns/10ps
module lsc_line_frontend (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      sda_level,
  output logic      start_det,
  output logic      stop_det
);
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
  } lsc_fe_s;

  lsc_fe_s s;
  lsc_fe_s next_s;

  // two-stage synchronisers plus one history stage
  always_comb begin
    next_s        = s;
    next_s.scl_s1 = scl_in;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_q  = s.scl_s2;
    next_s.sda_s1 = sda_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_q  = s.sda_s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  // edge and condition decode from synced stages
  assign scl_rise  = s.scl_s2 & ~s.scl_q;
  assign scl_fall  = ~s.scl_s2 & s.scl_q;
  assign sda_level = s.sda_s2;
  assign start_det = s.scl_s2 & s.scl_q & s.sda_q & ~s.sda_s2;
  assign stop_det  = s.scl_s2 & s.scl_q & ~s.sda_q & s.sda_s2;
endmodule

// ---- rtl/lsc_regs.sv ----
`timescale 1ns/10ps
// Operation
// - a set override bit forces its enabled output to full duty, else adaptive dimming
// - override register resets to zero, all outputs under adaptive dimming
// - six low enable bits, one per string, reset all enabled, upper bits zero
// - config bytes preload from the ordered variant; one variant is left blank
// - current-limit range and boost-range bits reset factory-set even when blank; host writes to 98h and 9eh can change them
module lsc_regs #(
  parameter logic [6:0] DEV_ADDR       = 7'h2c,
  parameter logic [7:0] IDENTITY       = 8'h5a, // arbitrary value
  parameter int         VARIANT        = lsc_pkg::VARIANT_A,
  parameter logic       FACTORY_ILIM   = 1'b0,
  parameter logic       FACTORY_VRANGE = 1'b1
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe,
  input  wire logic [lsc_pkg::NUM_OUTPUTS-1:0] adaptive_pwm,
  output logic [lsc_pkg::NUM_OUTPUTS-1:0]    led_drive,
  output logic [lsc_pkg::NUM_OUTPUTS-1:0]    out_full_duty,
  output logic [lsc_pkg::NUM_OUTPUTS-1:0]    string_enable_bits,
  output lsc_pkg::lsc_cfg_t                  cfg_bytes
);
  import lsc_pkg::*;

  // factory image chosen at build time
  localparam lsc_cfg_t CFG_RST = lsc_preload(VARIANT, FACTORY_ILIM, FACTORY_VRANGE);

  typedef struct packed {
    lsc_state_e             st;
    logic [3:0]             bitcnt;
    logic [7:0]             shreg;
    logic [7:0]             ptr;
    logic                   got_ptr;
    logic                   rw;
    logic                   nack;
    logic                   sda_low;
    logic [NUM_OUTPUTS-1:0] force_full;
    logic [NUM_OUTPUTS-1:0] enable;
    logic [NUM_OUTPUTS-1:0] drive;
    lsc_cfg_t               cfg;
  } lsc_regs_s;

  lsc_regs_s s;
  lsc_regs_s next_s;

  logic scl_rise;
  logic scl_fall;
  logic sda_level;
  logic start_det;
  logic stop_det;

  lsc_line_frontend u_frontend (
    .clk       (clk),
    .rst_n     (rst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .sda_level (sda_level),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // config address decode
  function automatic logic cfg_hit(input logic [7:0] a);
    return (a == ADDR_CFG98) || (a == ADDR_CFG9E) || (a[7:4] == ADDR_CFG_HI);
  endfunction

  function automatic logic [4:0] cfg_idx(input logic [7:0] a);
    logic [4:0] i;
    if (a == ADDR_CFG98) begin
      i = CFG_IDX_98;
    end else if (a == ADDR_CFG9E) begin
      i = CFG_IDX_9E;
    end else begin
      i = 5'({1'b0, a[3:0]}) + CFG_IDX_A0;
    end
    return i;
  endfunction

  // read mux, unmapped reads as zero
  function automatic logic [7:0] read_byte(input logic [7:0] a, input lsc_regs_s r);
    logic [7:0] d;
    d = 8'h00;
    if (a == ADDR_IDENTITY) begin
      d = IDENTITY;
    end else if (a == ADDR_FORCE) begin
      d = {2'h0, r.force_full};
    end else if (a == ADDR_ENABLE) begin
      d = {2'h0, r.enable};
    end else if (cfg_hit(a)) begin
      d = r.cfg[cfg_idx(a)];
    end
    return d;
  endfunction

  logic [7:0] rd;

  // bus sequencing and register updates
  always_comb begin
    next_s       = s;
    rd           = read_byte(s.ptr, s);
    next_s.drive = (s.force_full | adaptive_pwm) & s.enable;
    if (stop_det) begin
      next_s.st      = ST_IDLE;
      next_s.sda_low = 1'b0;
    end else if (start_det) begin
      next_s.st      = ST_ADDR;
      next_s.bitcnt  = 4'h0;
      next_s.got_ptr = 1'b0;
      next_s.sda_low = 1'b0;
    end else begin
      case (s.st)
        ST_ADDR: begin
          if (scl_rise) begin
            next_s.shreg  = {s.shreg[6:0], sda_level};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == BYTE_BITS) begin
            if (s.shreg[7:1] == DEV_ADDR) begin
              next_s.rw      = s.shreg[0];
              next_s.sda_low = 1'b1;
              next_s.st      = ST_ACK_ADDR;
            end else begin
              next_s.st = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            if (s.rw) begin
              next_s.shreg   = rd;
              next_s.sda_low = ~rd[7];
              next_s.ptr     = s.ptr + 8'h01;
              next_s.st      = ST_RBYTE;
            end else begin
              next_s.sda_low = 1'b0;
              next_s.st      = ST_WBYTE;
            end
          end
        end
        ST_WBYTE: begin
          if (scl_rise) begin
            next_s.shreg  = {s.shreg[6:0], sda_level};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == BYTE_BITS) begin
            next_s.sda_low = 1'b1;
            next_s.st      = ST_ACK_W;
            if (!s.got_ptr) begin
              next_s.ptr     = s.shreg;
              next_s.got_ptr = 1'b1;
            end else begin
              next_s.ptr = s.ptr + 8'h01;
              if (s.ptr == ADDR_FORCE) begin
                next_s.force_full = s.shreg[NUM_OUTPUTS-1:0];
              end else if (s.ptr == ADDR_ENABLE) begin
                next_s.enable = s.shreg[NUM_OUTPUTS-1:0];
              end else if (cfg_hit(s.ptr)) begin
                next_s.cfg[cfg_idx(s.ptr)] = s.shreg;
              end
              // identity and unmapped addresses drop the data
            end
          end
        end
        ST_ACK_W: begin
          if (scl_fall) begin
            next_s.sda_low = 1'b0;
            next_s.bitcnt  = 4'h0;
            next_s.st      = ST_WBYTE;
          end
        end
        ST_RBYTE: begin
          if (scl_rise) begin
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (s.bitcnt == BYTE_BITS) begin
              next_s.sda_low = 1'b0;
              next_s.st      = ST_ACK_R;
            end else begin
              next_s.shreg   = {s.shreg[6:0], 1'b0};
              next_s.sda_low = ~s.shreg[6];
            end
          end
        end
        ST_ACK_R: begin
          if (scl_rise) begin
            next_s.nack = sda_level;
          end else if (scl_fall) begin
            if (s.nack) begin
              next_s.st = ST_IDLE;
            end else begin
              next_s.shreg   = rd;
              next_s.sda_low = ~rd[7];
              next_s.ptr     = s.ptr + 8'h01;
              next_s.bitcnt  = 4'h0;
              next_s.st      = ST_RBYTE;
            end
          end
        end
        default: begin
          next_s.st      = ST_IDLE;
          next_s.sda_low = 1'b0;
        end
      endcase
    end
  end

  // state register with documented reset values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s            <= '0;
      s.st         <= ST_IDLE;
      s.force_full <= FORCE_RST;
      s.enable     <= ENABLE_RST;
      s.drive      <= ENABLE_RST & FORCE_RST;
      s.cfg        <= CFG_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign sda_out            = 1'b0; // open drain, only ever pulls low
  assign sda_oe             = s.sda_low;
  assign led_drive          = s.drive;
  assign out_full_duty      = s.force_full;
  assign string_enable_bits = s.enable;
  assign cfg_bytes          = s.cfg;
endmodule

// ---- tb/lsc_regs_props.sv ----
`timescale 1ns/10ps
module lsc_regs_props
  import lsc_pkg::*;
#(
  parameter int   VARIANT        = VARIANT_A,
  parameter logic FACTORY_ILIM   = 1'b0,
  parameter logic FACTORY_VRANGE = 1'b1
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [5:0] adaptive_pwm,
  input wire logic [5:0] led_drive,
  input wire logic [5:0] out_full_duty,
  input wire logic [5:0] string_enable_bits,
  input wire lsc_cfg_t   cfg_bytes
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // first edge after reset release
  sequence s_rel;
    $rose(rst_n);
  endsequence
  property p_frst;
    s_rel |-> out_full_duty == 6'h00;
  endproperty
  property p_erst;
    s_rel |-> string_enable_bits == 6'h3f;
  endproperty
  property p_fix;
    s_rel |-> VARIANT != 2 || (cfg_bytes[0][7] == FACTORY_ILIM && cfg_bytes[1][5] == FACTORY_VRANGE);
  endproperty
  property p_blank;
    s_rel |-> VARIANT != 2 || cfg_bytes[2:17] == '0;
  endproperty
  property p_drv;
    $past(rst_n) |-> led_drive == $past((out_full_duty | adaptive_pwm) & string_enable_bits);
  endproperty
  // registers and the data line move only while the bus clock is low
  property p_fupd;
    $changed(out_full_duty) |-> !scl_in;
  endproperty
  property p_eupd;
    $changed(string_enable_bits) |-> !scl_in;
  endproperty
  property p_oe;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  property p_od;
    sda_out == 1'b0;
  endproperty
  a_frst: assert property (p_frst) else $error("override not clear");
  a_erst: assert property (p_erst) else $error("enables not set");
  a_fix: assert property (p_fix) else $error("factory bits wrong");
  a_blank: assert property (p_blank) else $error("blank bytes set");
  a_drv: assert property (p_drv) else $error("drive mismatch");
  a_fupd: assert property (p_fupd) else $error("override moved");
  a_eupd: assert property (p_eupd) else $error("enable moved");
  a_oe: assert property (p_oe) else $error("data moved high");
  a_od: assert property (p_od) else $error("data driven high");
endmodule

// ---- tb/lsc_i2c_host.sv ----
`timescale 1ns/10ps
module lsc_i2c_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one pulse; releases or pulls data, samples eight cycles into the high phase
  task automatic bt(input logic b, input logic s, output logic r);
    sda_low = !b;
    hc(6);
    scl = 1'b1;
    hc(8);
    r = sda;
    sda_low = s;
    hc(s ? 8 : 0);
    scl = 1'b0;
    hc(4);
  endtask
  // eight bits msb first, then the acknowledge clock
  task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], !d[i], r);
      q[i] = r;
    end
    bt(m, !m, a);
  endtask
  // start, repeated start and stop conditions
  task automatic st();
    logic r;
    bt(1'b1, 1'b1, r);
  endtask
  task automatic sp();
    sda_low = 1'b1;
    hc(6);
    scl = 1'b1;
    hc(8);
    sda_low = 1'b0;
    hc(8);
  endtask
  task automatic wr(input logic [6:0] da, input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    st();
    xb({da, 1'b0}, 1'b1, q, a0);
    xb(p, 1'b1, q, a1);
    xb(d, 1'b1, q, a2);
    sp();
    ok = !(a0 | a1 | a2);
  endtask
  // pointer write, repeated start, one byte read ended by nack
  task automatic rd(input logic [6:0] da, input logic [7:0] p, output logic [7:0] q,
                    output logic ok);
    logic a0, a1, a2, a3;
    st();
    xb({da, 1'b0}, 1'b1, q, a0);
    xb(p, 1'b1, q, a1);
    st();
    xb({da, 1'b1}, 1'b1, q, a2);
    xb(8'hff, 1'b1, q, a3);
    sp();
    ok = !(a0 | a1 | a2);
  endtask
endmodule

// ---- tb/lsc_regs_tb_top.sv ----
`timescale 1ns/10ps
module lsc_regs_tb_top;
  import lsc_pkg::*;
  localparam logic [6:0] DA = 7'h2c;
  localparam logic [7:0] ID = 8'h96; // arbitrary value
  localparam logic [7:0] RL [5] = '{8'h03, 8'h04, 8'h16, 8'h98, 8'h9e};
  localparam logic [7:0] EL [4] = '{8'hdf, 8'hcf, 8'h00, 8'hff};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  pwm = 6'h00;
  logic        scl, sda_low, sda, sda_out, sda_oe, ok;
  logic [5:0]  drv, full, ena;
  logic [7:0]  q;
  logic [31:0] rs = 32'hc42da90a;
  lsc_cfg_t    cfg;
  int          failures = 0;
  int          checks = 0;
  int          mdl [256];
  always #2 clk = ~clk;
  assign sda = !(sda_low | sda_oe); // pull-up wire
  lsc_regs #(.DEV_ADDR(DA), .IDENTITY(ID), .VARIANT(2), .FACTORY_ILIM(1'b1),
    .FACTORY_VRANGE(1'b0)) i_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .adaptive_pwm(pwm), .led_drive(drv),
    .out_full_duty(full), .string_enable_bits(ena), .cfg_bytes(cfg));
  lsc_i2c_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // override and enable writes mirrored in the model, only six bits kept
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_host.wr(DA, p, d, ok);
    chk("write ack", {7'h0, ok}, 8'h01);
    if (p == ADDR_FORCE || p == ADDR_ENABLE) mdl[p] = d & 8'h3f;
  endtask
  task automatic rd(input logic [7:0] p);
    i_host.rd(DA, p, q, ok);
    chk("read ack", {7'h0, ok}, 8'h01);
    chk("read data", q, 8'(mdl[p]));
  endtask
  // fresh dimming input, then outputs against the model
  task automatic drv_chk();
    rs = nx(rs);
    pwm = rs[5:0];
    repeat (3) @(negedge clk);
    chk("drive", {2'b0, drv}, 8'((mdl[4] | pwm) & mdl[22]));
    chk("force", {2'b0, full}, 8'(mdl[4]));
    chk("enable", {2'b0, ena}, 8'(mdl[22]));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    mdl[3] = ID;
    mdl[22] = 'h3f;
    mdl[152] = 'h80;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    drv_chk();
    chk("cfg98", cfg[0], 8'h80);
    chk("cfg9e", cfg[1], 8'h00);
    chk("cfga0", cfg[2], 8'h00);
    foreach (RL[i]) rd(RL[i]);
    $display("test reset done");
    rs = nx(rs);
    wr(ADDR_IDENTITY, rs[7:0]);
    rd(ADDR_IDENTITY);
    for (int k = 0; k < 4; k++) begin
      rs = nx(rs);
      wr(ADDR_FORCE, k == 0 ? 8'hff : rs[15:8]);
      drv_chk();
      rd(ADDR_FORCE);
    end
    $display("test override done");
    // strings dropped from the top down, upper bits not kept
    foreach (EL[i]) begin
      wr(ADDR_ENABLE, EL[i]);
      drv_chk();
      rd(ADDR_ENABLE);
    end
    // foreign address ignored, unmapped place reads zero
    i_host.wr(DA ^ 7'h01, ADDR_FORCE, 8'h2a, ok);
    chk("foreign ack", {7'h0, ok}, 8'h00);
    wr(8'h50, 8'h77);
    rd(8'h50);
    drv_chk();
    // second reset in mid-run
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    mdl[4] = 0;
    mdl[22] = 'h3f;
    repeat (4) @(negedge clk);
    drv_chk();
    $display("test access done");
    tally_and_finish();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
bind lsc_regs lsc_regs_props #(.VARIANT(VARIANT), .FACTORY_ILIM(FACTORY_ILIM),
  .FACTORY_VRANGE(FACTORY_VRANGE)) i_props (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .adaptive_pwm(adaptive_pwm), .led_drive(led_drive),
  .out_full_duty(out_full_duty), .string_enable_bits(string_enable_bits),
  .cfg_bytes(cfg_bytes));
